// ### hdl/fpc_flash_program_control.sv
// Flash control and status registers, column latch routing and code read steering.
// Assumes the CPU core reports its execution context and the flash array
// reports programming completion, all on mclk.
`timescale 1ns/1ns
`default_nettype none
module fpc_flash_program_control
    import fpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Execution context
    input wire logic exec_boot_flash,
    input wire logic exec_external,
    input wire logic [2:0] lock_bits,
    input wire logic external_xdata_select,
    // External data write
    input wire logic xw_en,
    input wire logic [15:0] xw_addr,
    input wire logic [7:0] xw_data,
    output logic latch_wr,
    output logic [8:0] latch_page,
    output logic [6:0] latch_byte,
    output logic [7:0] latch_data,
    output logic xram_int_wr,
    output logic xram_ext_wr,
    // Code space read
    input wire logic cr_en,
    input wire logic [15:0] cr_addr,
    output logic cr_valid,
    output logic cr_refused,
    output logic [1:0] cr_space,
    // Flash array
    input wire logic prog_done,
    output logic prog_start,
    output logic [1:0] prog_space,
    output logic [8:0] prog_page,
    output logic latch_clear
);
    logic [3:0] key_reg;
    logic map_reg;
    logic [1:0] space_reg;
    logic busy_reg;
    logic sequence_error_reg;
    logic loaded_reg;
    logic ctl_wr, sta_wr, launch, seq_fail, latch_load, prog_go, clear_go;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic [7:0] ctl_value(input logic [3:0] k, input logic m,
                                            input logic [1:0] s, input logic b);
        ctl_value = {k, m, s, b};
    endfunction

    assign ctl_wr = sfr_wr && (sfr_addr == FPC_CONTROL_ADDR);
    assign sta_wr = sfr_wr && (sfr_addr == FPC_STATUS_ADDR);
    assign latch_load = xw_en && map_reg && (exec_boot_flash || exec_external);
    assign prog_go = launch && (fpc_space_t'(sfr_wdata[FPC_SPACE_HI:FPC_SPACE_LO]) != FPC_SPACE_LATCH_RESET);
    assign clear_go = launch && (fpc_space_t'(sfr_wdata[FPC_SPACE_HI:FPC_SPACE_LO]) == FPC_SPACE_LATCH_RESET);

    fpc_launch_seq u_seq (
        .mclk(mclk),
        .reset_n(reset_n),
        .ctl_wr(ctl_wr),
        .key_nibble(sfr_wdata[FPC_KEY_HI:FPC_KEY_LO]),
        .launch_allowed(exec_boot_flash && !busy_reg),
        .launch(launch),
        .seq_fail(seq_fail)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            key_reg <= FPC_CONTROL_RESET[FPC_KEY_HI:FPC_KEY_LO];
            map_reg <= FPC_CONTROL_RESET[FPC_MAP_BIT];
            space_reg <= FPC_CONTROL_RESET[FPC_SPACE_HI:FPC_SPACE_LO];
        end else if (ctl_wr) begin
            key_reg <= sfr_wdata[FPC_KEY_HI:FPC_KEY_LO];
            map_reg <= sfr_wdata[FPC_MAP_BIT];
            space_reg <= sfr_wdata[FPC_SPACE_HI:FPC_SPACE_LO];
        end
    end

    // Software writes never reach the busy flag.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy_reg <= FPC_CONTROL_RESET[FPC_BUSY_BIT];
        end else if (prog_go) begin
            busy_reg <= 1'b1;
        end else if (prog_done) begin
            busy_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sequence_error_reg <= FPC_STATUS_RESET[FPC_SEQUENCE_ERROR_BIT];
        end else if (seq_fail) begin
            sequence_error_reg <= 1'b1;
        end else if (launch) begin
            sequence_error_reg <= 1'b0;
        end else if (sta_wr && !sfr_wdata[FPC_SEQUENCE_ERROR_BIT]) begin
            sequence_error_reg <= 1'b0;
        end
    end

    // A byte landing in the same cycle as a launch keeps the flag set.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            loaded_reg <= FPC_STATUS_RESET[FPC_LOADED_BIT];
        end else if (latch_load) begin
            loaded_reg <= 1'b1;
        end else if (launch) begin
            loaded_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sfr_rdata <= FPC_ZERO_BYTE;
        end else if (sfr_rd && sfr_addr == FPC_CONTROL_ADDR) begin
            sfr_rdata <= ctl_value(key_reg, map_reg, space_reg, busy_reg);
        end else if (sfr_rd && sfr_addr == FPC_STATUS_ADDR) begin
            sfr_rdata <= {FPC_ZERO_BYTE[7:2], sequence_error_reg, loaded_reg};
        end else begin
            sfr_rdata <= FPC_ZERO_BYTE;
        end
    end

    // ------------------------------------------------------------
    // External data write routing
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            latch_wr <= 1'b0;
            xram_int_wr <= 1'b0;
            xram_ext_wr <= 1'b0;
        end else begin
            latch_wr <= latch_load;
            xram_int_wr <= xw_en && !map_reg && !external_xdata_select;
            xram_ext_wr <= xw_en && !map_reg && external_xdata_select;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            latch_page <= '0;
            latch_byte <= '0;
            latch_data <= FPC_ZERO_BYTE;
        end else if (xw_en) begin
            latch_page <= xw_addr[FPC_PAGE_HI:FPC_PAGE_LO];
            latch_byte <= xw_addr[FPC_BYTE_HI:FPC_BYTE_LO];
            latch_data <= xw_data;
        end
    end

    // ------------------------------------------------------------
    // Programming launch
    // ------------------------------------------------------------
    // The page programmed is that of the last latch load.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prog_start <= 1'b0;
            latch_clear <= 1'b0;
            prog_space <= FPC_SPACE_USER;
            prog_page <= '0;
        end else begin
            prog_start <= prog_go;
            latch_clear <= clear_go;
            if (prog_go) begin
                prog_space <= sfr_wdata[FPC_SPACE_HI:FPC_SPACE_LO];
            end
            if (latch_load) begin
                prog_page <= xw_addr[FPC_PAGE_HI:FPC_PAGE_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // Code space read steering
    // ------------------------------------------------------------
    // Reads only: this path has no write strobe at all.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cr_valid <= 1'b0;
            cr_refused <= 1'b0;
            cr_space <= FPC_SPACE_USER;
        end else begin
            cr_valid <= 1'b0;
            cr_refused <= 1'b0;
            cr_space <= space_reg;
            if (cr_en) begin
                if (exec_external && lock_bits != FPC_LOCKS_OPEN) begin
                    cr_refused <= 1'b1;
                end else begin
                    unique case (fpc_space_t'(space_reg))
                        FPC_SPACE_USER: cr_valid <= 1'b1;
                        FPC_SPACE_EXTRA_ROW: cr_valid <= (cr_addr >= FPC_EXTRA_ROW_BASE);
                        FPC_SPACE_SECURITY: cr_valid <= (cr_addr == FPC_SECURITY_ADDR);
                        FPC_SPACE_LATCH_RESET: cr_valid <= 1'b0;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Tracks the key of the last control write, since writes elsewhere may fall between the pair.
    logic unlock_seen_reg;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            unlock_seen_reg <= 1'b0;
        end else if (ctl_wr) begin
            unlock_seen_reg <= (sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_UNLOCK);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    start_busy_a: assert property (prog_start |-> busy_reg)
        else $error("program start without busy");
    busy_hold_a: assert property (busy_reg && !prog_done |=> busy_reg)
        else $error("busy dropped before done");
    boot_only_a: assert property (prog_go |-> exec_boot_flash)
        else $error("launch from wrong context");
    key_order_a: assert property (ctl_wr && unlock_seen_reg
        && sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_LAUNCH
        && exec_boot_flash && !busy_reg |=> prog_start || latch_clear)
        else $error("valid key pair did not launch");
    seq_err_a: assert property (ctl_wr && !unlock_seen_reg
        && sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_LAUNCH |=> sequence_error_reg && !prog_start)
        else $error("lone launch nibble not flagged");
    loaded_set_a: assert property (latch_load |=> loaded_reg && latch_wr)
        else $error("latch load not reported");
    loaded_clr_a: assert property (launch && !latch_load |=> !loaded_reg && !sequence_error_reg)
        else $error("success did not clear status");
    map_route_a: assert property (xw_en && map_reg |=> !xram_int_wr && !xram_ext_wr)
        else $error("mapped write reached data memory");
    latch_ctx_a: assert property (latch_wr |-> $past(exec_boot_flash || exec_external))
        else $error("latch load from user flash");
    lock_read_a: assert property (cr_en && exec_external && lock_bits != FPC_LOCKS_OPEN
        |=> cr_refused && !cr_valid)
        else $error("locked read granted");
    page_split_a: assert property (xw_en |=>
        latch_page == $past(xw_addr[FPC_PAGE_HI:FPC_PAGE_LO])
        && latch_byte == $past(xw_addr[FPC_BYTE_HI:FPC_BYTE_LO]))
        else $error("page split wrong");

    program_cov: cover property (prog_start ##[1:50] !busy_reg);
    latch_clear_cov: cover property (latch_clear);
    seq_fail_cov: cover property (seq_fail ##1 sequence_error_reg);
    extra_row_read_cov: cover property (cr_valid && cr_space == FPC_SPACE_EXTRA_ROW);
endmodule
`default_nettype wire

// ### hdl/fpc_pkg.sv
// Constants shared by the flash program control block and its key checker.
// Assumes an 8-bit special function register port driven by the CPU core.
package fpc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] FPC_CONTROL_ADDR = 8'hD1;
    localparam logic [7:0] FPC_STATUS_ADDR = 8'hD3;
    localparam logic [7:0] FPC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FPC_STATUS_RESET = 8'h00;
    localparam logic [7:0] FPC_ZERO_BYTE = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FPC_KEY_HI = 7;
    localparam int FPC_KEY_LO = 4;
    localparam int FPC_MAP_BIT = 3;
    localparam int FPC_SPACE_HI = 2;
    localparam int FPC_SPACE_LO = 1;
    localparam int FPC_BUSY_BIT = 0;
    localparam int FPC_SEQUENCE_ERROR_BIT = 1;
    localparam int FPC_LOADED_BIT = 0;
    localparam int FPC_PAGE_HI = 15;
    localparam int FPC_PAGE_LO = 7;
    localparam int FPC_BYTE_HI = 6;
    localparam int FPC_BYTE_LO = 0;
    // ------------------------------------------------------------
    // Launch key nibbles and space codes
    // ------------------------------------------------------------
    localparam logic [3:0] FPC_KEY_UNLOCK = 4'h5;
    localparam logic [3:0] FPC_KEY_LAUNCH = 4'hA;
    typedef enum logic [1:0] {
        FPC_SPACE_USER = 2'h0,
        FPC_SPACE_EXTRA_ROW = 2'h1,
        FPC_SPACE_SECURITY = 2'h2,
        FPC_SPACE_LATCH_RESET = 2'h3
    } fpc_space_t;
    // ------------------------------------------------------------
    // Code read windows and lock bits
    // ------------------------------------------------------------
    localparam logic [15:0] FPC_EXTRA_ROW_BASE = 16'hFF80;
    localparam logic [15:0] FPC_SECURITY_ADDR = 16'h0000;
    localparam logic [2:0] FPC_LOCKS_OPEN = 3'h7;
endpackage

// ### hdl/fpc_launch_seq.sv
// Two-write launch key checker for the flash control register.
// Assumes one strobe per control register write on the core clock.
`timescale 1ns/1ns
`default_nettype none
module fpc_launch_seq
    import fpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control register write
    input wire logic ctl_wr,
    input wire logic [3:0] key_nibble,
    input wire logic launch_allowed,
    // Result pulses
    output logic launch,
    output logic seq_fail
);
    typedef enum logic {FPC_IDLE, FPC_ARMED} fpc_seq_state_t;
    fpc_seq_state_t state_reg;

    // ------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= FPC_IDLE;
        end else if (ctl_wr) begin
            state_reg <= (key_nibble == FPC_KEY_UNLOCK) ? FPC_ARMED : FPC_IDLE;
        end
    end

    // Launch is taken only straight after the unlock write; a blocked context
    // is ignored silently rather than reported, since the core may be
    // legitimately running elsewhere.
    always_comb begin
        launch = 1'b0;
        seq_fail = 1'b0;
        if (ctl_wr) begin
            unique case (state_reg)
                FPC_IDLE: begin
                    seq_fail = (key_nibble == FPC_KEY_LAUNCH);
                end
                FPC_ARMED: begin
                    if (key_nibble == FPC_KEY_LAUNCH) begin
                        launch = launch_allowed;
                    end else begin
                        seq_fail = 1'b1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### sim/fpc_flash_model.sv
// Behavioural flash array that answers every launch with a completion pulse.
// Assumes launch pulses last one mclk cycle and never overlap a running job.
`timescale 1ns/1ns
`default_nettype none
module fpc_flash_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Pace select
    input wire logic slow,
    // Array side of the block
    input wire logic prog_start,
    input wire logic latch_clear,
    output logic prog_done
);
    // ------------------------------------------------------------
    // Job timer
    // ------------------------------------------------------------
    // A short and a long job time, so busy is seen both briefly and at length.
    logic [5:0] count_reg;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count_reg <= 6'h00;
            prog_done <= 1'b0;
        end else begin
            prog_done <= (count_reg == 6'h01);
            if (prog_start || latch_clear) begin
                count_reg <= slow ? 6'h28 : 6'h06;
            end else if (count_reg != 6'h00) begin
                count_reg <= count_reg - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the flash program control block.
// Assumes the flash array model answers every launch on its own.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import fpc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] F_RD = 8'h80, F_LW = 8'h40, F_XI = 8'h20, F_XE = 8'h10;
    localparam logic [7:0] F_PS = 8'h08, F_LC = 8'h04, F_CV = 8'h02, F_CF = 8'h01;
    logic mclk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, slow = 1'b0;
    logic exec_boot_flash = 1'b1, exec_external = 1'b0, external_xdata_select = 1'b0;
    logic xw_en = 1'b0, cr_en = 1'b0, rd_seen = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xw_data = 8'h00;
    logic [15:0] xw_addr = 16'h0000, cr_addr = 16'h0000;
    logic [2:0] lock_bits = 3'h7;
    logic [7:0] sfr_rdata, latch_data;
    logic latch_wr, xram_int_wr, xram_ext_wr, cr_valid, cr_refused, prog_done;
    logic prog_start, latch_clear;
    logic [8:0] latch_page, prog_page, last_page;
    logic [6:0] latch_byte;
    logic [1:0] cr_space, prog_space;
    logic [31:0] notes[$];
    int miscompares = 0, comparisons = 0, cycles = 0;
    always #4 mclk = ~mclk;
    fpc_flash_program_control dut (.mclk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .exec_boot_flash, .exec_external, .lock_bits, .external_xdata_select,
        .xw_en, .xw_addr, .xw_data, .latch_wr, .latch_page, .latch_byte, .latch_data,
        .xram_int_wr, .xram_ext_wr, .cr_en, .cr_addr, .cr_valid, .cr_refused, .cr_space,
        .prog_done, .prog_start, .prog_space, .prog_page, .latch_clear);
    fpc_flash_model model (.mclk, .reset_n, .slow, .prog_start, .latch_clear, .prog_done);
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        check("pending", notes.size(), 0);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        rd_seen <= sfr_rd;
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    // Every registered result is matched against the oldest expectation, or against zero as unexpected when none is pending.
    always @(negedge mclk) begin
        logic [7:0] f;
        logic [23:0] p;
        f = {rd_seen, latch_wr, xram_int_wr, xram_ext_wr, prog_start, latch_clear, cr_valid,
            cr_refused};
        p = rd_seen ? {16'h0000, sfr_rdata} : latch_wr ? {latch_page, latch_byte, latch_data}
            : prog_start ? {13'h0000, prog_space, prog_page}
            : (cr_valid || cr_refused) ? {22'h000000, cr_space} : 24'h000000;
        if (f !== 8'h00) begin
            if (notes.size() == 0) begin
                check("unexpected", {f, p}, 32'h00000000);
            end else begin
                check("result", {f, p}, notes.pop_front());
            end
        end
    end
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic note(input logic [7:0] f, input logic [23:0] p);
        notes.push_back({f, p});
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_r(input logic [7:0] a, input logic [7:0] d);
        note(F_RD, {16'h0000, d});
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
    endtask
    task automatic xwrite(input logic [15:0] a, input logic [7:0] d, input logic [7:0] f);
        if (f != 8'h00) begin
            note(f, f == F_LW ? {a[15:7], a[6:0], d} : 24'h000000);
        end
        @(negedge mclk);
        xw_addr = a;
        xw_data = d;
        xw_en = 1'b1;
        @(negedge mclk);
        xw_en = 1'b0;
    endtask
    task automatic launch(input logic [1:0] m, input logic go);
        sfr_w(FPC_CONTROL_ADDR, {FPC_KEY_UNLOCK, 1'b0, m, 1'b0});
        if (go) begin
            note(m == 2'h3 ? F_LC : F_PS, m == 2'h3 ? 24'h000000 : {13'h0000, m, last_page});
        end
        sfr_w(FPC_CONTROL_ADDR, {FPC_KEY_LAUNCH, 1'b0, m, 1'b0});
    endtask
    task automatic wait_done();
        int i;
        i = 0;
        while (prog_done !== 1'b1 && i < 100) begin
            @(negedge mclk);
            i++;
        end
        check("done", i < 100, 1);
        @(negedge mclk);
    endtask
    task automatic cread(input logic [1:0] m, input logic [15:0] a, input logic [2:0] lk,
        input logic ext, input logic [7:0] f);
        sfr_w(FPC_CONTROL_ADDR, {5'h00, m, 1'b0});
        if (f != 8'h00) begin
            note(f, {22'h000000, m});
        end
        @(negedge mclk);
        lock_bits = lk;
        exec_external = ext;
        exec_boot_flash = ~ext;
        cr_addr = a;
        cr_en = 1'b1;
        @(negedge mclk);
        cr_en = 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        void'($urandom(32'hBBCADAA8));
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        sfr_r(FPC_CONTROL_ADDR, FPC_CONTROL_RESET);
        sfr_r(FPC_STATUS_ADDR, FPC_STATUS_RESET);
        sfr_r(8'h80, FPC_ZERO_BYTE);
        {a, d} = 24'($urandom);
        xwrite(a, d, F_XI);
        external_xdata_select = 1'b1;
        xwrite(a, d, F_XE);
        sfr_w(FPC_CONTROL_ADDR, 8'h08);
        exec_boot_flash = 1'b0;
        xwrite(a, d, 8'h00);
        exec_external = 1'b1;
        xwrite(a, d, F_LW);
        exec_external = 1'b0;
        exec_boot_flash = 1'b1;
        for (int m = 0; m < 4; m++) begin
            {a, d} = 24'($urandom);
            sfr_w(FPC_CONTROL_ADDR, {5'h01, m[1:0], 1'b0});
            xwrite(a, d, F_LW);
            last_page = a[15:7];
            sfr_r(FPC_STATUS_ADDR, 8'h01);
            slow = (m == 0);
            launch(m[1:0], 1'b1);
            if (m == 0) begin
                sfr_r(FPC_CONTROL_ADDR, 8'hA1);
                sfr_w(FPC_CONTROL_ADDR, 8'h00);
                sfr_r(FPC_CONTROL_ADDR, 8'h01);
            end
            wait_done();
            if (m == 0) begin
                sfr_w(FPC_CONTROL_ADDR, 8'h01);
            end
            sfr_r(FPC_CONTROL_ADDR, m == 0 ? 8'h00 : {FPC_KEY_LAUNCH, 1'b0, m[1:0], 1'b0});
            sfr_r(FPC_STATUS_ADDR, 8'h00);
        end
        sfr_w(FPC_CONTROL_ADDR, 8'h50);
        sfr_w(FPC_CONTROL_ADDR, 8'h30);
        sfr_r(FPC_STATUS_ADDR, 8'h02);
        launch(2'h3, 1'b1);
        wait_done();
        sfr_r(FPC_STATUS_ADDR, 8'h00);
        sfr_w(FPC_CONTROL_ADDR, 8'hA0);
        sfr_r(FPC_STATUS_ADDR, 8'h02);
        sfr_w(FPC_STATUS_ADDR, 8'h00);
        sfr_r(FPC_STATUS_ADDR, 8'h00);
        exec_boot_flash = 1'b0;
        launch(2'h0, 1'b0);
        sfr_r(FPC_STATUS_ADDR, 8'h00);
        cread(2'h0, a, 3'h7, 1'b0, F_CV);
        cread(2'h1, 16'hFF90, 3'h7, 1'b0, F_CV);
        cread(2'h1, 16'h0010, 3'h7, 1'b0, 8'h00);
        cread(2'h2, 16'h0000, 3'h7, 1'b0, F_CV);
        cread(2'h2, 16'h0001, 3'h7, 1'b0, 8'h00);
        cread(2'h3, a, 3'h7, 1'b0, 8'h00);
        cread(2'h0, a, 3'h6, 1'b1, F_CF);
        cread(2'h0, a, 3'h7, 1'b1, F_CV);
        repeat (2) @(negedge mclk);
        conclude();
    end
endmodule
`default_nettype wire
